// >>> logic/conditional_branch_unit.v
// Purpose: execute flag-conditioned relative branches, owning the program counter
// Assumes: decoder pulses branch_valid_i with cond and offset for one cycle
// Notes: status flags are only read, never written
`default_nettype none
`include "cond_branch_regs.vh"
module conditional_branch_unit #(
   parameter PC_W  = 16,
   parameter OFF_W = 7
) (
   input  wire              core_clk_i,
   input  wire              reset_n_i,
   input  wire              advance_i,
   input  wire              branch_valid_i,
   input  wire [3:0]        cond_i,
   input  wire [OFF_W-1:0]  offset_i,
   input  wire [7:0]        flags_i,
   output reg  [PC_W-1:0]   pc_o,
   output reg               busy_o,
   output reg               taken_o,
   output reg               done_o
);
   // State codes and constants
   localparam ST_IDLE = 1'b0;
   localparam ST_JUMP = 1'b1;
   localparam [PC_W-1:0] PC_INIT = `PC_RESET;
   localparam [PC_W-1:0] PC_ONE  = {{(PC_W-1){1'b0}}, 1'b1};

   // Registered state
   reg             state;
   reg  [PC_W-1:0] target;

   // Next values
   reg             next_state;
   reg  [PC_W-1:0] next_pc;
   reg  [PC_W-1:0] next_target;
   reg             next_busy;
   reg             next_taken;
   reg             next_done;

   // Request decode
   wire            cond_true;
   wire            req_accept;
   wire            req_jump;
   wire            req_skip;
   wire            step_only;
   wire [PC_W-1:0] offset_ext;
   wire [PC_W-1:0] pc_offset;
   wire [PC_W-1:0] jump_target;
   wire [PC_W-1:0] pc_seq;

   // Program counter plus one, wrapping
   function [PC_W-1:0] incr_pc;
      input [PC_W-1:0] value;
      begin
         incr_pc = value + PC_ONE;
      end
   endfunction

   // High when a new request may be taken
   function is_idle;
      input st;
      begin
         is_idle = (st == ST_IDLE);
      end
   endfunction

   branch_cond_eval u_eval (
      .cond_i  (cond_i),
      .flags_i (flags_i),
      .taken_o (cond_true)
   );

   // sign extension
   // Low bits copied, high bits repeat the sign
   genvar g;
   generate
      for (g = 0; g < PC_W; g = g + 1) begin : g_ext
         if (g < OFF_W) begin : g_low
            assign offset_ext[g] = offset_i[g];
         end else begin : g_high
            assign offset_ext[g] = offset_i[OFF_W-1];
         end
      end
   endgenerate

   // Requests while busy are dropped silently
   assign req_accept  = branch_valid_i & is_idle(state);
   assign req_jump    = req_accept & cond_true;
   assign req_skip    = req_accept & ~cond_true;
   // Plain step only when no branch is present
   assign step_only   = ~branch_valid_i & advance_i & is_idle(state);
   assign pc_seq      = incr_pc(pc_o);
   assign pc_offset   = pc_o + offset_ext;
   assign jump_target = incr_pc(pc_offset);

   // one cycle skip, two cycle jump
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_jump) begin
               next_state = ST_JUMP;
            end else begin
               next_state = ST_IDLE;
            end
         end
         // Second cycle always returns to idle
         ST_JUMP: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Program counter and held jump target
   always @* begin
      next_pc     = pc_o;
      next_target = target;
      case (state)
         ST_IDLE: begin
            if (req_jump) begin
               next_target = jump_target;
            end else if (req_skip) begin
               next_pc = pc_seq;
            end else if (step_only) begin
               next_pc = pc_seq;
            end else begin
               next_pc = pc_o;
            end
         end
         // Jump lands two cycles after acceptance
         ST_JUMP: begin
            next_pc = target;
         end
         default: begin
            next_pc     = pc_o;
            next_target = target;
         end
      endcase
   end

   // Busy, taken and done pulses
   always @* begin
      next_busy  = 1'b0;
      next_taken = 1'b0;
      next_done  = 1'b0;
      case (state)
         // Done pulses once per branch
         ST_IDLE: begin
            next_busy = req_jump;
            next_done = req_skip;
         end
         ST_JUMP: begin
            next_taken = 1'b1;
            next_done  = 1'b1;
         end
         default: begin
            next_busy  = 1'b0;
            next_taken = 1'b0;
            next_done  = 1'b0;
         end
      endcase
   end

   // One process per register, outputs straight from flops
   // Sequencer state
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Program counter
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_o <= PC_INIT;
      end else begin
         pc_o <= next_pc;
      end
   end

   // Held jump target
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         target <= PC_INIT;
      end else begin
         target <= next_target;
      end
   end

   // Busy during the jump cycle
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= next_busy;
      end
   end

   // Taken pulse with the target load
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         taken_o <= 1'b0;
      end else begin
         taken_o <= next_taken;
      end
   end

   // Done pulse at the end of every branch
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= next_done;
      end
   end

endmodule // conditional_branch_unit
`default_nettype wire

// >>> inc/cond_branch_regs.vh
// Purpose: constants for the conditional branch unit
// Assumes: status flag order C,Z,N,V,S,H,T,I in bits 0..7
// Notes: How it works list follows
// How it works
// - Same-or-higher and carry-clear branches jump only when carry is zero.
// - Unsigned-lower branch jumps only when carry is one.
// - Negative branch jumps only when negative flag is one.
// - Non-negative branch jumps only when negative flag is zero.
// - Signed greater-or-equal jumps only when N xor V is zero.
// - Signed less-than jumps only when N xor V is one.
// - Half-carry-set branch jumps only when half-carry is one.
// - Half-carry-clear branch jumps only when half-carry is zero.
// - Transfer-bit-set branch jumps only when transfer bit is one.
`ifndef COND_BRANCH_REGS_VH
`define COND_BRANCH_REGS_VH
`define FLAG_C 0
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_H 5
`define FLAG_T 6
`define COND_NONE         4'h0
`define COND_CARRY_CLEAR  4'h1
`define COND_SAME_HIGHER  4'h2
`define COND_UNS_LOWER    4'h3
`define COND_NEGATIVE     4'h4
`define COND_NON_NEG      4'h5
`define COND_SIGNED_GE    4'h6
`define COND_SIGNED_LESS  4'h7
`define COND_HALF_SET     4'h8
`define COND_HALF_CLEAR   4'h9
`define COND_TBIT_SET     4'hA
`define PC_RESET          16'h0000
`endif

// >>> logic/branch_cond_eval.v
// Purpose: decide whether a conditional branch is taken
// Assumes: flags come from the status register, same clock
// Notes: purely combinational
`default_nettype none
`include "cond_branch_regs.vh"
module branch_cond_eval (
   input  wire [3:0] cond_i,
   input  wire [7:0] flags_i,
   output reg        taken_o
);
   wire c = flags_i[`FLAG_C];
   wire n = flags_i[`FLAG_N];
   wire v = flags_i[`FLAG_V];
   wire h = flags_i[`FLAG_H];
   wire t = flags_i[`FLAG_T];
   always @* begin
      case (cond_i)
         `COND_CARRY_CLEAR,
         `COND_SAME_HIGHER: taken_o = ~c;
         `COND_UNS_LOWER:   taken_o = c;
         `COND_NEGATIVE:    taken_o = n;
         `COND_NON_NEG:     taken_o = ~n;
         `COND_SIGNED_GE:   taken_o = ~(n ^ v);
         `COND_SIGNED_LESS: taken_o = n ^ v;
         `COND_HALF_SET:    taken_o = h;
         `COND_HALF_CLEAR:  taken_o = ~h;
         `COND_TBIT_SET:    taken_o = t;
         default:           taken_o = 1'b0;
      endcase
   end
endmodule // branch_cond_eval
`default_nettype wire

// >>> test/cbu_checker.sv
// Purpose: port checks for the branch unit
// Assumes: flags C0 N2 V3 H5 T6, codes 1 to A
// Notes: bound to the top module below
`default_nettype none
module cbu_checker #(parameter PC_W = 16, parameter OFF_W = 7) (
   input wire logic core_clk_i, reset_n_i, advance_i, branch_valid_i, busy_o, taken_o, done_o,
   input wire logic [3:0] cond_i,
   input wire logic [7:0] flags_i,
   input wire logic [OFF_W-1:0] offset_i,
   input wire logic [PC_W-1:0] pc_o);
   timeunit 1ns;
   timeprecision 1ns;
   wire [7:0] f = flags_i;
   wire [15:0] tv = {5'h00, f[6], !f[5], f[5], f[2] ^ f[3], f[2] ~^ f[3], !f[2], f[2], f[0],
      !f[0], !f[0], 1'h0};
   wire rq = branch_valid_i && !busy_o;
   wire t = tv[cond_i];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence jump_s; busy_o ##1 taken_o && done_o; endsequence
   chk_jump_two:
      assert property (rq && t |=> jump_s) else $error("jump timing");
   chk_skip_one:
      assert property (rq && !t |=> done_o && !busy_o) else $error("skip timing");
   chk_skip_pc: assert property (rq && !t |=> pc_o == $past(pc_o) + 1'b1) else $error("skip");
   chk_target_pc:
      assert property (rq && t |=> ##1 pc_o == $past(pc_o, 2)
         + PC_W'($signed($past(offset_i, 2))) + 1'b1) else $error("target");
   chk_busy_one: assert property (busy_o |=> !busy_o) else $error("busy long");
   chk_busy_pc: assert property (busy_o |-> $stable(pc_o) && !done_o) else $error("hold");
   chk_taken_done: assert property (taken_o |-> done_o && $past(busy_o)) else $error("td");
   chk_done_src:
      assert property (done_o |-> $past(branch_valid_i) || $past(busy_o)) else $error("done");
   chk_step_pc:
      assert property (!branch_valid_i && advance_i && !busy_o |=> pc_o == $past(pc_o) + 1'b1)
         else $error("step");
   chk_idle_hold:
      assert property (!branch_valid_i && !advance_i && !busy_o |=> $stable(pc_o) && !done_o)
         else $error("idle hold");
endmodule // cbu_checker
bind conditional_branch_unit cbu_checker #(.PC_W(PC_W), .OFF_W(OFF_W)) chk (
   .core_clk_i     (core_clk_i),
   .reset_n_i      (reset_n_i),
   .advance_i      (advance_i),
   .branch_valid_i (branch_valid_i),
   .busy_o         (busy_o),
   .taken_o        (taken_o),
   .done_o         (done_o),
   .cond_i         (cond_i),
   .flags_i        (flags_i),
   .offset_i       (offset_i),
   .pc_o           (pc_o)
);
`default_nettype wire

// >>> test/tb_conditional_branch_unit.sv
// Purpose: bench for the branch unit
// Assumes: inputs driven on the falling edge
// Notes: rows hold cond, flags and jump
`default_nettype none
module tb_conditional_branch_unit;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
   logic core_clk_i = 0, reset_n_i = 0, advance_i = 0, branch_valid_i = 0, busy_o, taken_o, done_o;
   logic [3:0] cond_i = 0;
   logic [7:0] flags_i = 0;
   logic [6:0] offset_i = 0;
   logic [15:0] pc_o, p;
   int mismatches = 0, num_checks = 0, i, k;
   logic [15:0] rows [20] = '{16'h1001, 16'h2010, 16'h3011, 16'h3000, 16'h4041, 16'h4000,
      16'h5001, 16'h5040, 16'h60C1, 16'h6040, 16'h7081, 16'h70C0, 16'h8201, 16'h8DF0,
      16'h9DF1, 16'h9200, 16'hA401, 16'hABF0, 16'hFFF0, 16'h0FF0};
   always #10 core_clk_i = ~core_clk_i;
   conditional_branch_unit dut (
      .core_clk_i     (core_clk_i),
      .reset_n_i      (reset_n_i),
      .advance_i      (advance_i),
      .branch_valid_i (branch_valid_i),
      .cond_i         (cond_i),
      .offset_i       (offset_i),
      .flags_i        (flags_i),
      .pc_o           (pc_o),
      .busy_o         (busy_o),
      .taken_o        (taken_o),
      .done_o         (done_o)
   );
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Request held through busy, so a refused repeat is exercised too
   task automatic br(input logic [15:0] r);
      p = pc_o;
      {branch_valid_i, cond_i, flags_i} = {1'b1, r[15:4]};
      @(negedge core_clk_i);
      `CHK("busy", r[0], busy_o)
      for (k = 1; k < 4 && done_o !== 1'b1; k++) @(negedge core_clk_i);
      if (k == 4) begin
         mismatches++;
         $display("[ERR] done exp 1 got %b", done_o);
         end_sim;
      end else begin
         `CHK("taken", r[0], taken_o)
         `CHK("cycles", {r[0], !r[0]}, k[1:0])
         `CHK("pc", p + (r[0] ? {{9{offset_i[6]}}, offset_i} : 16'h0000) + 16'h0001, pc_o)
      end
   endtask
   initial begin
      repeat (6) @(negedge core_clk_i);
      `CHK("reset pc", 16'h0000, pc_o)
      `CHK("reset busy", 1'b0, busy_o)
      `CHK("reset done", 1'b0, done_o)
      `CHK("reset taken", 1'b0, taken_o)
      $display("reset test done");
      reset_n_i = 1;
      for (i = 0; i < 20; i++) begin
         offset_i = 7'(i * 13);
         br(rows[i]);
      end
      $display("table done");
      advance_i = 1;
      offset_i = 7'h40;
      br(16'h1001);
      branch_valid_i = 0;
      @(negedge core_clk_i);
      `CHK("step", p + 16'hFFC2, pc_o)
      advance_i = 0;
      repeat (2) @(negedge core_clk_i);
      `CHK("hold", p + 16'hFFC2, pc_o)
      $display("step test done");
      reset_n_i = 0;
      #1;
      `CHK("mid reset", 16'h0000, pc_o)
      `CHK("mid busy", 1'b0, busy_o)
      @(negedge core_clk_i);
      reset_n_i = 1;
      offset_i = 7'h05;
      br(16'hA401);
      branch_valid_i = 0;
      p = pc_o;
      @(negedge core_clk_i);
      `CHK("idle", p, pc_o)
      $display("mid reset test done");
      end_sim;
   end
endmodule // tb_conditional_branch_unit
`default_nettype wire
